// ### inc/alu_consts.svh
// Purpose: offsets, field positions, reset values of the arithmetic unit
// Assumes: included by every design file that needs them
// Notes: byte addresses on the register bus
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH
`define REG_CTRL 8'h00
`define REG_DEST 8'h04
`define REG_SRC 8'h08
`define REG_IMM 8'h0c
`define REG_STATUS 8'h10
`define STATUS_BUSY_BIT 8
`define OP_FIELD_W 5
`define OP_COUNT 5'h12
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAGS_W 6
`define MASK_ARITH 6'h2f
`define MASK_LOGIC 6'h0e
`define MASK_INVERSE 6'h0f
`define MASK_WORD 6'h1f
`define MASK_NONE 6'h00
`define FLAGS_RESET 6'h00
`define DEST_RESET 16'h0000
`define BYTE_RESET 8'h00
`define ALL_ONES 8'hff
`endif

// ### inc/alu_pkg.sv
// Purpose: types shared by the arithmetic unit files
// Assumes: nothing
// Notes: op codes follow the enum order
package alu_pkg;
  typedef enum logic [4:0] {
    op_add, op_add_carry, op_sub, op_sub_borrow, op_sub_const,
    op_sub_borrow_const, op_and, op_and_const, op_or, op_or_const,
    op_xor, op_ones_inverse, op_bit_set, op_bit_clear, op_plus_one,
    op_minus_one, op_word_sum, op_word_diff
  } op_t;
  typedef enum logic [1:0] {
    st_idle, st_byte, st_word_lo, st_word_hi
  } state_t;
endpackage : alu_pkg

// ### hdl/byte_alu_core.sv
// Purpose: combinational 8-bit arithmetic and logic step
// Assumes: only the basic ops reach it; constant forms mapped outside
// Notes: carry output means borrow for subtraction
`timescale 1ns/1ps
`default_nettype none
`include "alu_consts.svh"
module byte_alu_core
  import alu_pkg::*;
(
  input wire op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output logic [7:0] res,
  output logic c,
  output logic v,
  output logic h
);
  wire is_sub = (op == op_sub) || (op == op_sub_borrow);
  wire use_cin = (op == op_add_carry) || (op == op_sub_borrow);
  wire [8:0] ci9 = {8'h00, use_cin & cin};
  wire [4:0] ci5 = {4'h0, use_cin & cin};
  wire [8:0] sum9 = is_sub ? ({1'b0, a} - {1'b0, b} - ci9)
                           : ({1'b0, a} + {1'b0, b} + ci9);
  wire [4:0] nib5 = is_sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - ci5)
                           : ({1'b0, a[3:0]} + {1'b0, b[3:0]} + ci5);
  wire r7 = sum9[7];
  wire v_add = (a[7] & b[7] & ~r7) | (~a[7] & ~b[7] & r7);
  wire v_sub = (a[7] & ~b[7] & ~r7) | (~a[7] & b[7] & r7);

  always_comb begin
    res = sum9[7:0];
    c = sum9[8];
    v = is_sub ? v_sub : v_add;
    h = nib5[4];
    case (op)
      op_add, op_add_carry, op_sub, op_sub_borrow: begin
      end
      op_and: begin
        res = a & b;
        v = 1'b0;
      end
      op_or: begin
        res = a | b;
        v = 1'b0;
      end
      op_xor: begin
        res = a ^ b;
        v = 1'b0;
      end
      op_ones_inverse: begin
        res = `ALL_ONES - a;
        c = 1'b1;
        v = 1'b0;
      end
      op_plus_one: begin
        res = a + 8'h01;
        v = (a == 8'h7f);
      end
      op_minus_one: begin
        res = a - 8'h01;
        v = (a == 8'h80);
      end
      default: begin
        res = a;
        c = 1'b0;
        v = 1'b0;
        h = 1'b0;
      end
    endcase
  end
endmodule : byte_alu_core
`default_nettype wire

// ### hdl/flag_merge.sv
// Purpose: forms the new status flags from a result and an update mask
// Assumes: wide selects the 16-bit view of the result
// Notes: flags outside the mask keep their old value
`timescale 1ns/1ps
`default_nettype none
`include "alu_consts.svh"
module flag_merge (
  input wire logic [`FLAGS_W-1:0] old_flags,
  input wire logic [`FLAGS_W-1:0] mask,
  input wire logic [15:0] res16,
  input wire logic wide,
  input wire logic c,
  input wire logic v,
  input wire logic h,
  output logic [`FLAGS_W-1:0] new_flags
);
  wire z = wide ? (res16 == 16'h0000) : (res16[7:0] == 8'h00);
  wire n = wide ? res16[15] : res16[7];
  logic [`FLAGS_W-1:0] calc;
  always_comb begin
    calc = `FLAGS_RESET;
    calc[`FLAG_C] = c;
    calc[`FLAG_Z] = z;
    calc[`FLAG_N] = n;
    calc[`FLAG_V] = v;
    calc[`FLAG_S] = n ^ v;
    calc[`FLAG_H] = h;
  end
  genvar i;
  generate
    for (i = 0; i < `FLAGS_W; i++) begin : g_bit
      assign new_flags[i] = mask[i] ? calc[i] : old_flags[i];
    end
  endgenerate
endmodule : flag_merge
`default_nettype wire

// ### hdl/eight_bit_arith_logic_unit.sv
// Purpose: 8-bit arithmetic and logic unit with 16-bit pair ops, on APB
// Assumes: one clock; a write to the control word starts an operation
// Notes: the bus stalls while an operation runs
// Function
// - register sum, carry sum, five flags, one clock
// - pair plus constant, five flags, two clocks
// - pair minus constant, five flags, two clocks
// - register difference, borrow variant, one clock
// - destination minus constant, one clock
// - destination minus constant minus carry
// - AND with register or constant
// - OR with register or constant
// - XOR of registers, Z N V only
// - ones inverse sets Z C N V
// - bit set mask ORs constant in
// - bit clear mask ANDs inverted constant
// - plus one keeps carry
// - minus one keeps carry
`timescale 1ns/1ps
`default_nettype none
`include "alu_consts.svh"
module eight_bit_arith_logic_unit
  import alu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [`FLAGS_W-1:0] status_flags
);
  state_t state_reg;
  op_t op_reg;
  logic [15:0] dest_reg;
  logic [7:0] src_reg;
  logic [7:0] imm_reg;
  logic [`FLAGS_W-1:0] flags_reg;
  logic word_carry_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  wire busy = (state_reg != st_idle);
  wire access = psel & penable;
  // answer one cycle into the access phase, never while busy
  wire first_edge = access & ~pready_reg & ~busy;
  wire done = access & pready_reg;
  wire wr = done & pwrite & ~pslverr_reg;
  wire sel_ctrl = (paddr == `REG_CTRL);
  wire sel_dest = (paddr == `REG_DEST);
  wire sel_src = (paddr == `REG_SRC);
  wire sel_imm = (paddr == `REG_IMM);
  wire sel_stat = (paddr == `REG_STATUS);
  wire mapped = sel_ctrl | sel_dest | sel_src | sel_imm | sel_stat;
  wire op_ok = (pwdata[`OP_FIELD_W-1:0] < `OP_COUNT);
  wire bad = ~mapped | (pwrite & sel_ctrl & ~op_ok);
  wire op_t new_op = op_t'(pwdata[`OP_FIELD_W-1:0]);
  wire start = wr & sel_ctrl;
  wire new_is_word = (new_op == op_word_sum) || (new_op == op_word_diff);

  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_data[`OP_FIELD_W-1:0] = op_reg;
    end else if (sel_dest) begin
      rd_data[15:0] = dest_reg;
    end else if (sel_src) begin
      rd_data[7:0] = src_reg;
    end else if (sel_imm) begin
      rd_data[7:0] = imm_reg;
    end else if (sel_stat) begin
      rd_data[`FLAGS_W-1:0] = flags_reg;
      rd_data[`STATUS_BUSY_BIT] = busy;
    end
  end

  // map each operation onto the core and pick the flags it may touch
  op_t core_op;
  logic [7:0] core_b;
  logic core_cin;
  logic [`FLAGS_W-1:0] upd_mask;
  wire carry_in = flags_reg[`FLAG_C];
  wire hi_step = (state_reg == st_word_hi);
  always_comb begin
    core_op = op_reg;
    core_b = src_reg;
    core_cin = carry_in;
    upd_mask = `MASK_LOGIC;
    case (op_reg)
      op_add, op_add_carry: upd_mask = `MASK_ARITH;
      op_sub, op_sub_borrow: upd_mask = `MASK_ARITH;
      op_sub_const: begin
        core_op = op_sub;
        core_b = imm_reg;
        upd_mask = `MASK_ARITH;
      end
      op_sub_borrow_const: begin
        core_op = op_sub_borrow;
        core_b = imm_reg;
        upd_mask = `MASK_ARITH;
      end
      op_and: upd_mask = `MASK_LOGIC;
      op_and_const: begin
        core_op = op_and;
        core_b = imm_reg;
      end
      op_or: upd_mask = `MASK_LOGIC;
      op_or_const: begin
        core_op = op_or;
        core_b = imm_reg;
      end
      op_xor: upd_mask = `MASK_LOGIC;
      op_ones_inverse: upd_mask = `MASK_INVERSE;
      op_bit_set: begin
        core_op = op_or;
        core_b = imm_reg;
      end
      op_bit_clear: begin
        core_op = op_and;
        core_b = `ALL_ONES - imm_reg;
      end
      op_plus_one: upd_mask = `MASK_LOGIC;
      op_minus_one: upd_mask = `MASK_LOGIC;
      // low byte adds constant, high byte takes carry
      op_word_sum: begin
        core_op = hi_step ? op_add_carry : op_add;
        core_b = hi_step ? `BYTE_RESET : imm_reg;
        core_cin = word_carry_reg;
        upd_mask = `MASK_WORD;
      end
      // low byte subtracts constant, high byte the borrow
      op_word_diff: begin
        core_op = hi_step ? op_sub_borrow : op_sub;
        core_b = hi_step ? `BYTE_RESET : imm_reg;
        core_cin = word_carry_reg;
        upd_mask = `MASK_WORD;
      end
      default: upd_mask = `MASK_NONE;
    endcase
  end

  logic [7:0] core_res;
  logic core_c;
  logic core_v;
  logic core_h;
  wire [7:0] core_a = hi_step ? dest_reg[15:8] : dest_reg[7:0];
  byte_alu_core u_core (
    .op(core_op),
    .a(core_a),
    .b(core_b),
    .cin(core_cin),
    .res(core_res),
    .c(core_c),
    .v(core_v),
    .h(core_h)
  );

  // byte steps judge the fresh result, the high step the whole pair
  wire [15:0] flag_res = hi_step ? {core_res, dest_reg[7:0]}
                                 : {dest_reg[15:8], core_res};
  logic [`FLAGS_W-1:0] flags_calc;
  flag_merge u_flags (
    .old_flags(flags_reg),
    .mask(upd_mask),
    .res16(flag_res),
    .wide(hi_step),
    .c(core_c),
    .v(core_v),
    .h(core_h),
    .new_flags(flags_calc)
  );

  // flags move at the end of an operation or on a bus write to the status register
  wire flags_upd = (state_reg == st_byte) | hi_step;
  wire [`FLAGS_W-1:0] flags_next = flags_upd ? flags_calc
                                 : (wr & sel_stat)
                                 ? pwdata[`FLAGS_W-1:0] : flags_reg;
  wire lo_upd = (state_reg == st_byte) | (state_reg == st_word_lo);
  wire [15:0] dest_next = lo_upd ? {dest_reg[15:8], core_res}
                        : hi_step ? {core_res, dest_reg[7:0]}
                        : (wr & sel_dest) ? pwdata[15:0] : dest_reg;

  state_t state_next;
  always_comb begin
    case (state_reg)
      st_idle: begin
        state_next = st_idle;
        if (start) begin
          state_next = new_is_word ? st_word_lo : st_byte;
        end
      end
      st_word_lo: state_next = st_word_hi;
      default: state_next = st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_idle;
      op_reg <= op_add;
      dest_reg <= `DEST_RESET;
      flags_reg <= `FLAGS_RESET;
      word_carry_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start) begin
        op_reg <= new_op;
      end
      dest_reg <= dest_next;
      flags_reg <= flags_next;
      if (state_reg == st_word_lo) begin
        word_carry_reg <= core_c;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= `BYTE_RESET;
      imm_reg <= `BYTE_RESET;
    end else begin
      if (wr & sel_src) begin
        src_reg <= pwdata[7:0];
      end
      if (wr & sel_imm) begin
        imm_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= first_edge;
      pslverr_reg <= first_edge & bad;
      if (first_edge) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign status_flags = flags_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire [7:0] d8 = dest_reg[7:0];
  wire fc = flags_reg[`FLAG_C];
  wire in_byte = (state_reg == st_byte);
  sequence word_start_s;
    start && new_is_word;
  endsequence
  sequence word_run_s;
    busy [*2] ##1 !busy;
  endsequence

  a_carry_sum: assert property (
    in_byte && op_reg == op_add_carry |=>
      d8 == 8'($past(d8) + $past(src_reg) + {7'h00, $past(fc)}))
    else $error("carry sum result wrong");
  a_word_sum: assert property (
    word_start_s and (new_op == op_word_sum) |=> word_run_s ##0
      dest_reg == 16'($past(dest_reg, 3) + {8'h00, $past(imm_reg, 3)}))
    else $error("pair sum wrong or not two clocks");
  a_word_diff: assert property (
    word_start_s and (new_op == op_word_diff) |=> word_run_s ##0
      fc == ($past(dest_reg, 3) < {8'h00, $past(imm_reg, 3)}))
    else $error("pair difference borrow wrong");
  a_borrow_diff: assert property (
    in_byte && op_reg == op_sub_borrow |=>
      fc == ({1'b0, $past(d8)} < {1'b0, $past(src_reg)} + {8'h00, $past(fc)}))
    else $error("borrow difference carry wrong");
  a_const_diff: assert property (
    in_byte && op_reg == op_sub_const |=>
      d8 == 8'($past(d8) - $past(imm_reg)))
    else $error("constant difference wrong");
  a_borrow_const: assert property (
    in_byte && op_reg == op_sub_borrow_const |=>
      d8 == 8'($past(d8) - $past(imm_reg) - {7'h00, $past(fc)}))
    else $error("borrow constant difference wrong");
  a_mask_flags: assert property (
    in_byte && op_reg == op_and_const |=> !flags_reg[`FLAG_V] && $stable(fc)
      && d8 == ($past(d8) & $past(imm_reg)))
    else $error("constant mask wrong");
  a_merge_value: assert property (
    in_byte && op_reg == op_or |=> d8 == ($past(d8) | $past(src_reg)))
    else $error("register merge wrong");
  a_xor_value: assert property (
    in_byte && op_reg == op_xor |=> d8 == ($past(d8) ^ $past(src_reg))
      && $stable(flags_reg[`FLAG_H]))
    else $error("register xor wrong");
  a_inverse: assert property (
    in_byte && op_reg == op_ones_inverse |=> d8 == ~$past(d8) && fc)
    else $error("ones inverse wrong");
  a_clear_mask: assert property (
    in_byte && op_reg == op_bit_clear |=> d8 == ($past(d8) & ~$past(imm_reg)))
    else $error("bit clear mask wrong");
  a_plus_keeps_c: assert property (
    in_byte && op_reg == op_plus_one |=> $stable(fc)
      && d8 == 8'($past(d8) + 8'h01))
    else $error("plus one wrong");
  a_byte_timing: assert property (
    start && !new_is_word |=> in_byte ##1 !busy
      && $stable(flags_reg[`FLAG_S]))
    else $error("byte op not one clock");
  a_sign_flag: assert property (
    hi_step |=> flags_reg[`FLAG_S] == (flags_reg[`FLAG_N]
      ^ flags_reg[`FLAG_V]))
    else $error("sign flag not N xor V");
endmodule : eight_bit_arith_logic_unit
`default_nettype wire

// ### dv/apb_master.sv
// Purpose: APB requester standing in for the decoder and register file
// Assumes: xfer is entered just after a rising clock edge
// Notes: released lines show the inverse of the last request
`timescale 1ns/1ps
`default_nettype none
module apb_master (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // no cycle count assumed; the bench watchdog bounds a stuck slave
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~wd;
    @(posedge pclk);
  endtask : xfer
endmodule : apb_master
`default_nettype wire

// ### dv/testbench.sv
// Purpose: self-checking bench for the arithmetic unit over APB
// Assumes: operands are loaded through registers, result read back
// Notes: expected results come from a local model of each operation
`timescale 1ns/1ps
`default_nettype none
`include "alu_consts.svh"
module testbench
  import alu_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [`FLAGS_W-1:0] status_flags;
  int n_fail;
  int checks;

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  eight_bit_arith_logic_unit i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .status_flags(status_flags));
  apb_master i_mst (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic e, output logic [31:0] q);
    logic err;
    i_mst.xfer(w, a, d, q, err);
    cmp("pslverr", {31'h0, e}, {31'h0, err});
  endtask : bus

  // flags {H,S,V,N,Z,C}; result in [21:6]
  function automatic logic [21:0] model(input op_t op,
      input logic [15:0] d, input logic [7:0] s, input logic [7:0] k,
      input logic [5:0] f);
    logic [7:0] a, b, r;
    logic [8:0] sum, dif;
    logic [4:0] hs, hd;
    logic [16:0] w;
    logic ci, c, v, h, n;
    logic [5:0] m;
    a = d[7:0];
    b = (op inside {op_sub_const, op_sub_borrow_const, op_and_const,
        op_or_const, op_bit_set, op_bit_clear}) ? k : s;
    ci = (op inside {op_add_carry, op_sub_borrow, op_sub_borrow_const})
        & f[0];
    sum = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    dif = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    hd = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
    c = 1'b0;
    v = 1'b0;
    h = 1'b0;
    m = 6'h0e;
    r = 8'h00;
    case (op)
      op_add, op_add_carry: begin
        r = sum[7:0];
        c = sum[8];
        h = hs[4];
        m = 6'h2f;
        v = (a[7] == b[7]) && (r[7] != a[7]);
      end
      op_sub, op_sub_borrow, op_sub_const, op_sub_borrow_const: begin
        r = dif[7:0];
        c = dif[8];
        h = hd[4];
        m = 6'h2f;
        v = (a[7] != b[7]) && (r[7] != a[7]);
      end
      op_and, op_and_const: r = a & b;
      op_or, op_or_const, op_bit_set: r = a | b;
      op_xor: r = a ^ b;
      op_bit_clear: r = a & (8'hff - b);
      op_ones_inverse: begin
        r = 8'hff - a;
        c = 1'b1;
        m = 6'h0f;
      end
      op_plus_one: begin
        r = a + 8'h01;
        v = (a == 8'h7f);
      end
      op_minus_one: begin
        r = a - 8'h01;
        v = (a == 8'h80);
      end
      default: begin
        w = (op == op_word_sum) ? {1'b0, d} + {9'h0, k}
            : {1'b0, d} - {9'h0, k};
        n = w[15];
        v = (op == op_word_sum) ? (~d[15] & n) : (d[15] & ~n);
        return {w[15:0], (f & 6'h20) |
            {1'b0, n ^ v, v, n, w[15:0] == 16'h0000, w[16]}};
      end
    endcase
    return {d[15:8], r, (f & ~m) | ({h, 1'b0, v, r[7], r == 8'h00, c} & m)};
  endfunction : model

  task automatic run_op(input op_t op, input logic [15:0] d,
      input logic [7:0] s, input logic [7:0] k, input logic [5:0] f);
    logic [21:0] e;
    logic [31:0] q;
    e = model(op, d, s, k, f);
    bus(1'b1, `REG_STATUS, {26'h0, f}, 1'b0, q);
    bus(1'b1, `REG_DEST, {16'h0, d}, 1'b0, q);
    bus(1'b1, `REG_SRC, {24'h0, s}, 1'b0, q);
    bus(1'b1, `REG_IMM, {24'h0, k}, 1'b0, q);
    bus(1'b1, `REG_CTRL, {27'h0, op}, 1'b0, q);
    bus(1'b0, `REG_DEST, 32'h0, 1'b0, q);
    cmp("result", {16'h0, e[21:6]}, q);
    bus(1'b0, `REG_STATUS, 32'h0, 1'b0, q);
    cmp("flags", {26'h0, e[5:0]}, q);
    cmp("flag port", {26'h0, e[5:0]}, {26'h0, status_flags});
  endtask : run_op

  task automatic t_reset();
    logic [7:0] regs [5] = '{`REG_CTRL, `REG_DEST, `REG_SRC, `REG_IMM,
        `REG_STATUS};
    logic [31:0] q;
    foreach (regs[i]) begin
      bus(1'b0, regs[i], 32'h0, 1'b0, q);
      cmp("reset value", 32'h0, q);
    end
  endtask : t_reset

  // boundary operands: sign edges, nibble carry, carry in set and clear
  task automatic t_bytes(input int lo, input int hi);
    logic [7:0] vd [5] = '{8'h7f, 8'h80, 8'h0f, 8'h00, 8'hff};
    logic [7:0] vs [5] = '{8'h01, 8'h80, 8'h01, 8'hff, 8'h01};
    logic [7:0] vk [5] = '{8'h80, 8'h01, 8'h0f, 8'hff, 8'h7f};
    logic [5:0] vf [5] = '{6'h3f, 6'h00, 6'h01, 6'h3e, 6'h1f};
    for (int i = lo; i <= hi; i++) begin
      foreach (vd[j]) begin
        run_op(op_t'(i), {8'ha5, vd[j]}, vs[j], vk[j], vf[j]);
      end
    end
  endtask : t_bytes

  task automatic t_words();
    run_op(op_word_sum, 16'hffff, 8'h00, 8'h01, 6'h3f);
    run_op(op_word_sum, 16'h7fff, 8'h00, 8'h01, 6'h00);
    run_op(op_word_sum, 16'h00c0, 8'h00, 8'hff, 6'h20);
    run_op(op_word_diff, 16'h0000, 8'h00, 8'h01, 6'h00);
    run_op(op_word_diff, 16'h8000, 8'h00, 8'h01, 6'h3f);
    run_op(op_word_diff, 16'h01ff, 8'h00, 8'hff, 6'h00);
  endtask : t_words

  task automatic t_refuse();
    logic [31:0] q;
    bus(1'b1, `REG_DEST, 32'h0000_1234, 1'b0, q);
    bus(1'b1, `REG_CTRL, 32'h0000_0012, 1'b1, q);
    bus(1'b1, `REG_CTRL, 32'h0000_001f, 1'b1, q);
    bus(1'b0, 8'h14, 32'h0, 1'b1, q);
    bus(1'b0, `REG_DEST, 32'h0, 1'b0, q);
    cmp("dest after refusal", 32'h0000_1234, q);
  endtask : t_refuse

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  initial begin
    presetn = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_bytes(0, 5);
    t_bytes(6, 10);
    t_bytes(11, 13);
    t_bytes(14, 15);
    t_words();
    t_refuse();
    end_of_test();
  end

  // several times the expected length of the run
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
